//--- common/abbx_pkg.sv
`default_nettype none

package abbx_pkg;

    // --------------------------------------------------------------
    // Operation codes issued by the decoder
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ABBX_OP_NOP   = 3'h0,
        ABBX_OP_ADD   = 3'h1,
        ABBX_OP_ADDC  = 3'h2,
        ABBX_OP_BCLR  = 3'h3,
        ABBX_OP_BSET  = 3'h4,
        ABBX_OP_TSKC  = 3'h5,
        ABBX_OP_TSKS  = 3'h6,
        ABBX_OP_RJMP  = 3'h7
    } abbx_op_t;

    // --------------------------------------------------------------
    // Widths and positions
    // --------------------------------------------------------------
    localparam int unsigned ABBX_DW      = 8;
    localparam int unsigned ABBX_AW      = 7;
    localparam int unsigned ABBX_PCW     = 15;
    localparam int unsigned ABBX_OFSW    = 9;
    localparam int unsigned ABBX_HC_BIT  = 4;
    localparam int unsigned ABBX_CY_BIT  = 8;

    // --------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] ABBX_REG_ACC    = 8'h00;
    localparam logic [7:0] ABBX_REG_FLAGS  = 8'h04;
    localparam logic [7:0] ABBX_REG_PC     = 8'h08;
    localparam logic [7:0] ABBX_REG_STATE  = 8'h0C;
    localparam int unsigned ABBX_FLG_C     = 0;
    localparam int unsigned ABBX_FLG_HC    = 1;
    localparam int unsigned ABBX_FLG_Z     = 2;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0]  ABBX_ACC_RST   = 8'h00;
    localparam logic [2:0]  ABBX_FLG_RST   = 3'h0;
    localparam logic [14:0] ABBX_PC_RST    = 15'h0000;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int unsigned ABBX_CLK_NS    = 100;
    localparam int unsigned ABBX_LONG_CYC  = 2;

endpackage : abbx_pkg

`default_nettype wire

//--- hdl/abbx_adder.sv
`timescale 1ns/1ps
`default_nettype none

module abbx_adder
    import abbx_pkg::*;
(
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    input  wire logic       cin_i,
    output logic      [7:0] sum_o,
    output logic            carry_o,
    output logic            half_o,
    output logic            zero_o
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        full    = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
        low     = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
        sum_o   = full[7:0];
        carry_o = full[ABBX_CY_BIT];
        half_o  = low[ABBX_HC_BIT];
        zero_o  = (full[7:0] == 8'h00);
    end

endmodule : abbx_adder

`default_nettype wire

//--- hdl/abbx_exec.sv
`timescale 1ns/1ps
`default_nettype none

module abbx_exec
    import abbx_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Decoded instruction
    input  wire logic        issue_i,
    input  wire logic [2:0]  op_i,
    input  wire logic        jump_acc_i,
    input  wire logic [6:0]  file_addr_i,
    input  wire logic        dest_i,
    input  wire logic [2:0]  bit_idx_i,
    input  wire logic [8:0]  offset_i,
    output logic             ready_o,
    output logic             discard_o,
    // Data memory
    output logic [6:0]       mem_addr_o,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             mem_we_o,
    output logic [7:0]       mem_wdata_o,
    // Program counter (already incremented value)
    output logic [14:0]      program_counter_o,
    output logic             pc_load_o,
    // Visible state
    output logic [7:0]       acc_o,
    output logic             carry_flag_o,
    output logic             half_carry_flag_o,
    output logic             zero_flag_o,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ABBX_ST_EXEC  = 2'b01,
        ABBX_ST_FLUSH = 2'b10
    } abbx_state_t;

    abbx_state_t  state_q, state_d;
    logic [7:0]   acc_q, acc_d;
    logic         c_q, c_d, hc_q, hc_d, z_q, z_d;
    logic [14:0]  pc_q, pc_d;
    logic         pc_load_q, pc_load_d;
    logic         mem_we_q, mem_we_d;
    logic [7:0]   mem_wdata_q, mem_wdata_d;
    logic [6:0]   mem_addr_q, mem_addr_d;
    logic         ack_q, ack_d;
    logic [31:0]  rdat_q, rdat_d;

    logic [7:0]   sum;
    logic         sum_c, sum_hc, sum_z;
    logic         add_cin;
    logic         sel_bit;
    logic [7:0]   bit_mask;
    logic         wb_req;
    logic         take;
    abbx_op_t     op;

    assign op      = abbx_op_t'(op_i);
    assign add_cin = (op == ABBX_OP_ADDC) ? c_q : 1'b0;
    assign sel_bit = mem_rdata_i[bit_idx_i];
    assign bit_mask = 8'h01 << bit_idx_i;
    assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
    // One address port: hold off a new instruction while a file write is pending,
    // otherwise the write lands at the wrong address and a re-read sees stale data
    assign take    = issue_i && !mem_we_q;

    abbx_adder u_adder (
        .a_i     (acc_q),
        .b_i     (mem_rdata_i),
        .cin_i   (add_cin),
        .sum_o   (sum),
        .carry_o (sum_c),
        .half_o  (sum_hc),
        .zero_o  (sum_z)
    );

    // ----------------------------------------------------------------
    // Execution
    // ----------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        acc_d       = acc_q;
        c_d         = c_q;
        hc_d        = hc_q;
        z_d         = z_q;
        pc_d        = pc_q;
        pc_load_d   = 1'b0;
        mem_we_d    = 1'b0;
        mem_wdata_d = mem_wdata_q;
        mem_addr_d  = mem_addr_q;
        unique case (state_q)
            ABBX_ST_EXEC: begin
                if (take) begin
                    mem_addr_d = file_addr_i;
                    unique case (op)
                        ABBX_OP_ADD, ABBX_OP_ADDC: begin
                            c_d  = sum_c;
                            hc_d = sum_hc;
                            z_d  = sum_z;
                            if (dest_i) begin
                                mem_we_d    = 1'b1;
                                mem_wdata_d = sum;
                            end else begin
                                acc_d = sum;
                            end
                        end
                        ABBX_OP_BCLR: begin
                            mem_we_d    = 1'b1;
                            mem_wdata_d = mem_rdata_i & ~bit_mask;
                        end
                        ABBX_OP_BSET: begin
                            mem_we_d    = 1'b1;
                            mem_wdata_d = mem_rdata_i | bit_mask;
                        end
                        ABBX_OP_TSKC: begin
                            if (!sel_bit) begin
                                state_d = ABBX_ST_FLUSH;
                            end
                        end
                        ABBX_OP_TSKS: begin
                            if (sel_bit) begin
                                state_d = ABBX_ST_FLUSH;
                            end
                        end
                        ABBX_OP_RJMP: begin
                            pc_load_d = 1'b1;
                            state_d   = ABBX_ST_FLUSH;
                            if (jump_acc_i) begin
                                pc_d = pc_q + {7'h00, acc_q};
                            end else begin
                                pc_d = pc_q + {{6{offset_i[8]}}, offset_i};
                            end
                        end
                        ABBX_OP_NOP: begin
                        end
                    endcase
                    if (!pc_load_d) begin
                        pc_d = pc_q + 15'h0001;
                    end
                end
            end
            ABBX_ST_FLUSH: begin
                // Discarded slot counts as a no-operation that still advances
                state_d = ABBX_ST_EXEC;
                pc_d    = pc_q + 15'h0001;
            end
            default: state_d = ABBX_ST_EXEC;
        endcase
        if (wb_req && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                ABBX_REG_ACC:   acc_d = wb_dat_i[7:0];
                ABBX_REG_FLAGS: begin
                    c_d  = wb_dat_i[ABBX_FLG_C];
                    hc_d = wb_dat_i[ABBX_FLG_HC];
                    z_d  = wb_dat_i[ABBX_FLG_Z];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave: one registered ack per request, the cycle after it
    // ----------------------------------------------------------------
    always_comb begin
        ack_d  = wb_req;
        rdat_d = 32'h0000_0000;
        if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                ABBX_REG_ACC:   rdat_d = {24'h00_0000, acc_q};
                ABBX_REG_FLAGS: rdat_d = {29'h0000_0000, z_q, hc_q, c_q};
                ABBX_REG_PC:    rdat_d = {17'h0_0000, pc_q};
                ABBX_REG_STATE: rdat_d = {30'h0000_0000, state_q};
                default:        rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ABBX_ST_EXEC;
            acc_q       <= ABBX_ACC_RST;
            c_q         <= 1'b0;
            hc_q        <= 1'b0;
            z_q         <= 1'b0;
            pc_q        <= ABBX_PC_RST;
            pc_load_q   <= 1'b0;
            mem_we_q    <= 1'b0;
            mem_wdata_q <= 8'h00;
            mem_addr_q  <= 7'h00;
            ack_q       <= 1'b0;
            rdat_q      <= 32'h0000_0000;
        end else begin
            state_q     <= state_d;
            acc_q       <= acc_d;
            c_q         <= c_d;
            hc_q        <= hc_d;
            z_q         <= z_d;
            pc_q        <= pc_d;
            pc_load_q   <= pc_load_d;
            mem_we_q    <= mem_we_d;
            mem_wdata_q <= mem_wdata_d;
            mem_addr_q  <= mem_addr_d;
            ack_q       <= ack_d;
            rdat_q      <= rdat_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign ready_o           = (state_q == ABBX_ST_EXEC) && !mem_we_q;
    assign discard_o         = (state_q == ABBX_ST_FLUSH);
    assign mem_addr_o        = take ? file_addr_i : mem_addr_q;
    assign mem_we_o          = mem_we_q;
    assign mem_wdata_o       = mem_wdata_q;
    assign program_counter_o = pc_q;
    assign pc_load_o         = pc_load_q;
    assign acc_o             = acc_q;
    assign carry_flag_o      = c_q;
    assign half_carry_flag_o = hc_q;
    assign zero_flag_o       = z_q;
    assign wb_dat_o          = rdat_q;
    assign wb_ack_o          = ack_q;

endmodule : abbx_exec

`default_nettype wire

//--- tb/abbx_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module abbx_exec_monitor
    import abbx_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        issue_i,
    input wire logic [2:0]  op_i,
    input wire logic        jump_acc_i,
    input wire logic [2:0]  bit_idx_i,
    input wire logic [8:0]  offset_i,
    input wire logic        ready_o,
    input wire logic        discard_o,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic        mem_we_o,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic [14:0] program_counter_o,
    input wire logic        pc_load_o,
    input wire logic [7:0]  acc_o,
    input wire logic        carry_flag_o,
    input wire logic        zero_flag_o,
    input wire logic        dest_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic go;
    // A bus write to ACC or FLAGS in the same cycle overrides the instruction's result, so any bus write is left out
    assign go = issue_i && ready_o && !(wb_cyc_i && wb_stb_i && wb_we_i);
    logic tbit;
    assign tbit = mem_rdata_i[bit_idx_i];
    sequence s_slot_lost;
        discard_o && !ready_o ##1 ready_o && !discard_o;
    endsequence
    sequence s_slot_kept;
        ready_o && !discard_o;
    endsequence
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer too long");
    chk_skip_clear: assert property (go && op_i == ABBX_OP_TSKC && !tbit
        |=> s_slot_lost) else $error("skip on clear bit missed");
    chk_skip_set_kept: assert property (go && op_i == ABBX_OP_TSKS && !tbit
        |=> s_slot_kept) else $error("skip on clear bit taken");
    chk_jump_offset: assert property (go && op_i == ABBX_OP_RJMP && !jump_acc_i
        |=> pc_load_o && program_counter_o == $past(program_counter_o)
            + 15'($signed($past(offset_i))) ##0 s_slot_lost) else $error("offset jump wrong");
    chk_jump_acc: assert property (go && op_i == ABBX_OP_RJMP && jump_acc_i
        |=> program_counter_o == $past(program_counter_o) + 15'($past(acc_o)) ##0 s_slot_lost)
        else $error("accumulator jump wrong");
    chk_bit_set: assert property (go && op_i == ABBX_OP_BSET
        |=> mem_we_o && mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << $past(bit_idx_i)))
            && $stable(carry_flag_o) && $stable(zero_flag_o)) else $error("bit set wrong");
    chk_add_flags: assert property (go && op_i == ABBX_OP_ADD && !dest_i
        |=> {carry_flag_o, acc_o} == 9'($past(acc_o)) + 9'($past(mem_rdata_i))
            && zero_flag_o == (acc_o == 8'h00)) else $error("add result wrong");
    chk_skip_set: assert property (go && op_i == ABBX_OP_TSKS && tbit
        |=> s_slot_lost) else $error("skip on set bit missed");
    chk_bit_clear: assert property (go && op_i == ABBX_OP_BCLR
        |=> mem_we_o && mem_wdata_o == ($past(mem_rdata_i) & ~(8'h01 << $past(bit_idx_i)))
            && $stable(carry_flag_o) && $stable(zero_flag_o)) else $error("bit clear wrong");
    chk_file_write: assert property (go && op_i == ABBX_OP_ADD && dest_i
        |=> mem_we_o && mem_wdata_o == 8'($past(acc_o) + $past(mem_rdata_i))
            && $stable(acc_o)) else $error("add to file wrong");
endmodule : abbx_exec_monitor
`default_nettype wire

//--- tb/abbx_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module abbx_exec_bench
    import abbx_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0, jump_acc_i = 1'b0, dest_i = 1'b0;
    logic [2:0]  op_i = 3'h0, bit_idx_i = 3'h0;
    logic [6:0]  file_addr_i = 7'h00, mem_addr_o;
    logic [8:0]  offset_i = 9'h000, s;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, dsc, rdy, ld, xs;
    logic [7:0]  wb_adr_i = 8'h00, mem_rdata_i, mem_wdata_o, acc_o, mem [128];
    logic [3:0]  wb_sel_i = 4'hf;
    logic [4:0]  hs;
    logic [2:0]  opc, flg;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic [14:0] program_counter_o, pcb, pce, t;
    logic        ready_o, discard_o, mem_we_o, pc_load_o, carry_flag_o, half_carry_flag_o, zero_flag_o;
    logic [7:0]  av [4] = '{8'h71, 8'h0a, 8'hff, 8'h12};
    logic [7:0]  fv [4] = '{8'h8f, 8'h06, 8'h00, 8'h34};
    logic [8:0]  jv [3] = '{9'h0ff, 9'h100, 9'h000};
    int          mismatches = 0, checks_done = 0;
    always #50 clk_i = ~clk_i;
    assign mem_rdata_i = mem[mem_addr_o];
    assign flg = {carry_flag_o, half_carry_flag_o, zero_flag_o};
    always @(posedge clk_i) if (mem_we_o) mem[mem_addr_o] <= mem_wdata_o;
    abbx_exec u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i), .op_i(op_i), .jump_acc_i(jump_acc_i),
        .file_addr_i(file_addr_i), .dest_i(dest_i), .bit_idx_i(bit_idx_i), .offset_i(offset_i),
        .ready_o(ready_o), .discard_o(discard_o), .mem_addr_o(mem_addr_o),
        .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
        .program_counter_o(program_counter_o), .pc_load_o(pc_load_o), .acc_o(acc_o),
        .carry_flag_o(carry_flag_o), .half_carry_flag_o(half_carry_flag_o),
        .zero_flag_o(zero_flag_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        checks_done++;
        if (v !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic results();
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Only the watchdog ends a wait for an answer that never comes
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : bus
    task automatic ins(input logic [2:0] op, input logic ja, input logic [6:0] fa, input logic d,
                       input logic [2:0] b, input logic [8:0] off);
        pcb = program_counter_o;
        @(posedge clk_i);
        issue_i <= 1'b1;
        op_i <= op;
        jump_acc_i <= ja;
        file_addr_i <= fa;
        dest_i <= d;
        bit_idx_i <= b;
        offset_i <= off;
        @(posedge clk_i);
        issue_i <= 1'b0;
        #1;
        {dsc, rdy, ld, pce} = {discard_o, ready_o, pc_load_o, program_counter_o};
        // The extra edge lets a pending file write land before the next access
        @(posedge clk_i);
        #1;
    endtask : ins
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("reset", 32'h0000_0000, {program_counter_o, acc_o, carry_flag_o, zero_flag_o});
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ABBX_REG_FLAGS, {31'h0000_0000, i[0]});
            bus(1'b1, ABBX_REG_ACC, {24'h00_0000, av[i]});
            mem[7'h7f - i] = fv[i];
            s = {1'b0, av[i]} + fv[i] + (i > 1 ? i[0] : 1'b0);
            hs = {1'b0, av[i][3:0]} + fv[i][3:0] + (i > 1 ? i[0] : 1'b0);
            opc = i > 1 ? ABBX_OP_ADDC : ABBX_OP_ADD;
            ins(opc, 1'b0, 7'h7f - i, i[0], 3'h0, 9'h000);
            chk("acc", i[0] ? av[i] : s[7:0], acc_o);
            chk("file", i[0] ? s[7:0] : fv[i], mem[7'h7f - i]);
            chk("flags", {s[8], hs[4], s[7:0] == 8'h00}, flg);
            chk("count", pcb + 15'h0001, program_counter_o);
        end
        bus(1'b1, ABBX_REG_FLAGS, 32'h0000_0005);
        bus(1'b0, ABBX_REG_FLAGS, 32'h0000_0000);
        chk("flags reg", 32'h0000_0005, rd);
        bus(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        for (int b = 0; b < 8; b++) begin
            mem[7'h05] = 8'ha5;
            ins(ABBX_OP_BSET, 1'b0, 7'h05, 1'b0, b[2:0], 9'h000);
            chk("bit set", 8'ha5 | (8'h01 << b), mem[7'h05]);
            ins(ABBX_OP_BCLR, 1'b0, 7'h05, 1'b0, b[2:0], 9'h000);
            chk("bit clear", 8'ha5 & ~(8'h01 << b), mem[7'h05]);
            chk("bit flags", 3'b101, flg);
        end
        for (int k = 0; k < 4; k++) begin
            mem[7'h20] = k[0] ? 8'h08 : 8'hf7;
            xs = k[1] ~^ k[0];
            opc = k[1] ? ABBX_OP_TSKS : ABBX_OP_TSKC;
            ins(opc, 1'b0, 7'h20, 1'b0, 3'h3, 9'h000);
            chk("skip", {xs, !xs}, {dsc, rdy});
            chk("skip count", pcb + 15'h0001 + xs, program_counter_o);
        end
        bus(1'b1, ABBX_REG_ACC, 32'h0000_00ff);
        for (int j = 0; j < 3; j++) begin
            ins(ABBX_OP_RJMP, j == 2, 7'h00, 1'b0, 3'h0, jv[j]);
            t = pcb + (j == 2 ? 15'h00ff : {{6{jv[j][8]}}, jv[j]});
            chk("target", t, pce);
            chk("load", 2'b11, {ld, dsc});
            chk("after", t + 15'h0001, program_counter_o);
        end
        chk("jump flags", 3'b101, flg);
        bus(1'b0, ABBX_REG_PC, 32'h0000_0000);
        chk("counter reg", t + 15'h0001, rd);
        bus(1'b0, ABBX_REG_ACC, 32'h0000_0000);
        chk("acc reg", 32'h0000_00ff, rd);
        bus(1'b0, ABBX_REG_STATE, 32'h0000_0000);
        chk("state reg", 32'h0000_0001, rd);
        results();
    end
    initial begin
        #200_000;
        mismatches++;
        results();
    end
endmodule : abbx_exec_bench
bind abbx_exec abbx_exec_monitor u_mon (.*);
`default_nettype wire
